// file: logic/cati_pkg.sv
// constants and register map of the counter array timebase and interrupt block
// =====================================================================
// Operation
// - 16-bit counter; low byte read latches high byte snapshot for next high read
// - counter reads never disturb counting
// - select 000 counts every 12 clocks, 001 every 4, 100 every clock
// - select 011 counts external input falling edges, source at most clock/4
// - select 101 counts external oscillator divided by 8, synchronized first
// - wrap from all ones to zero sets the overflow flag
// - overflow flag requests an interrupt only while its enable is set
// - hardware never clears the overflow flag on vectoring; software clears it
// - idle halt clear: counting continues while processor idles
// - five modules, each with its own io line through the crossbar
// - all six event flags set on trigger regardless of enables
// - each flag contributes only with its own enable
// - interrupt recognized only with global and array enables both set
// - module 4 watchdog mode after reset restricts certain register writes
package cati_pkg;
    // =================================================================
    // geometry
    localparam int NUM_MODULES = 5;
    localparam int CNT_W       = 16;
    localparam int BYTE_W      = 8;
    // =================================================================
    // timebase
    localparam logic [2:0] TB_DIV12  = 3'h0;
    localparam logic [2:0] TB_DIV4   = 3'h1;
    localparam logic [2:0] TB_T0_OVF = 3'h2;
    localparam logic [2:0] TB_EXT_IN = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_OSC8   = 3'h5;
    localparam int         DIV_SLOW  = 12;
    localparam int         DIV_FAST  = 4;
    localparam int         OSC_DIV   = 8;
    // =================================================================
    // register byte addresses
    localparam logic [7:0] ADDR_MODE   = 8'h00;
    localparam logic [7:0] ADDR_FLAGS  = 8'h04;
    localparam logic [7:0] ADDR_IRQEN  = 8'h08;
    localparam logic [7:0] ADDR_CNT_LO = 8'h0c;
    localparam logic [7:0] ADDR_CNT_HI = 8'h10;
    localparam logic [7:0] ADDR_IO     = 8'h14;
    // mode register fields
    localparam int MODE_IDLE_BIT = 0;
    localparam int MODE_TB_LSB   = 1;
    localparam int MODE_OVF_EN   = 4;
    localparam int MODE_WDOG     = 5;
    // flags: bit 0 overflow, bits 5:1 module events
    localparam int FLAG_OVF      = 0;
    localparam int FLAG_MOD_LSB  = 1;
    // irq enable: bits 4:0 module enables, bit 5 array enable
    localparam int IRQ_ARRAY_BIT = 5;
    // io register: bits 4:0 line level, bits 12:8 crossbar enable
    localparam int IO_OE_LSB     = 8;
    // =================================================================
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: logic/cati_sync.sv
// two flip-flop synchronizer for asynchronous pin levels
`timescale 1ns/10ps
module cati_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // cati_sync

// file: logic/cati_timebase.sv
// counter advance pulse generation from the selected timebase
`timescale 1ns/10ps
module cati_timebase (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // selection
    input  wire logic [2:0] tb_sel,
    // sources, already synchronized where they come from pins
    input  wire logic       timer0_ovf,
    input  wire logic       ext_count_sync,
    input  wire logic       ext_osc_sync,
    // advance pulse
    output logic            tick
);
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic       ext_prev_q;
    logic       ext_prev_d;
    logic       osc_prev_q;
    logic       osc_prev_d;
    logic [2:0] osc_cnt_q;
    logic [2:0] osc_cnt_d;
    logic       tick_q;
    logic       tick_d;
    logic       osc_rise;

    always_comb begin
        pre_d      = (pre_q == 4'(cati_pkg::DIV_SLOW - 1)) ? 4'h0 : pre_q + 4'h1;
        ext_prev_d = ext_count_sync;
        osc_prev_d = ext_osc_sync;
        osc_rise   = ext_osc_sync & ~osc_prev_q;
        osc_cnt_d  = osc_rise ? osc_cnt_q + 3'h1 : osc_cnt_q;
        case (tb_sel)
            cati_pkg::TB_DIV12:  tick_d = (pre_q == 4'(cati_pkg::DIV_SLOW - 1));
            cati_pkg::TB_DIV4:
                tick_d = (pre_q[1:0] == 2'(cati_pkg::DIV_FAST - 1));
            cati_pkg::TB_T0_OVF: tick_d = timer0_ovf;
            cati_pkg::TB_EXT_IN: tick_d = ext_prev_q & ~ext_count_sync;
            cati_pkg::TB_SYSCLK: tick_d = 1'b1;
            cati_pkg::TB_OSC8:
                tick_d = osc_rise && (osc_cnt_q == 3'(cati_pkg::OSC_DIV - 1));
            default:             tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q      <= 4'h0;
            ext_prev_q <= 1'b0; // synchronizer resets low: no false edge
            osc_prev_q <= 1'b0;
            osc_cnt_q  <= 3'h0;
            tick_q     <= 1'b0;
        end else begin
            pre_q      <= pre_d;
            ext_prev_q <= ext_prev_d;
            osc_prev_q <= osc_prev_d;
            osc_cnt_q  <= osc_cnt_d;
            tick_q     <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule // cati_timebase

// file: logic/cati_top.sv
// counter array: 16-bit timebase counter, event flags and interrupt request
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module cati_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // axi4-lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // core side
    input  wire logic        global_irq_enable,
    input  wire logic        cpu_idle,
    input  wire logic        timer0_ovf,
    input  wire logic [4:0]  module_event,
    output logic             array_irq,
    // pins
    input  wire logic        ext_count_input,
    input  wire logic        ext_osc_in,
    output logic [4:0]       module_io_line,
    output logic [4:0]       module_io_oe
);
    localparam int NM = cati_pkg::NUM_MODULES;

    // =================================================================
    // state
    logic [15:0]   cnt_q,      cnt_d;
    logic [7:0]    snap_q,     snap_d;
    logic          idle_halt_q, idle_halt_d;
    logic [2:0]    tb_sel_q,   tb_sel_d;
    logic          ovf_en_q,   ovf_en_d;
    logic          wdog_q,     wdog_d;
    logic [NM:0]   flags_q,    flags_d;
    logic [NM-1:0] mod_en_q,   mod_en_d;
    logic          array_en_q, array_en_d;
    logic [NM-1:0] io_q,       io_d;
    logic [NM-1:0] io_oe_q,    io_oe_d;
    logic          irq_q,      irq_d;
    // bus
    logic          aw_have_q,  aw_have_d;
    logic [7:0]    aw_addr_q,  aw_addr_d;
    logic          w_have_q,   w_have_d;
    logic [31:0]   w_data_q,   w_data_d;
    logic [3:0]    w_strb_q,   w_strb_d;
    logic          bvalid_q,   bvalid_d;
    logic [1:0]    bresp_q,    bresp_d;
    logic          rvalid_q,   rvalid_d;
    logic [31:0]   rdata_q,    rdata_d;
    logic [1:0]    rresp_q,    rresp_d;

    logic          tick;
    logic          ext_count_sync;
    logic          ext_osc_sync;

    // =================================================================
    // pin synchronizers and timebase
    cati_sync #(
        .WIDTH (2)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({ext_osc_in, ext_count_input}),
        .sync_out ({ext_osc_sync, ext_count_sync})
    );

    cati_timebase u_timebase (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .tb_sel         (tb_sel_q),
        .timer0_ovf     (timer0_ovf),
        .ext_count_sync (ext_count_sync),
        .ext_osc_sync   (ext_osc_sync),
        .tick           (tick)
    );

    // =================================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == cati_pkg::ADDR_MODE)   || (a == cati_pkg::ADDR_FLAGS) ||
               (a == cati_pkg::ADDR_IRQEN)  || (a == cati_pkg::ADDR_CNT_LO) ||
               (a == cati_pkg::ADDR_CNT_HI) || (a == cati_pkg::ADDR_IO);
    endfunction

    // =================================================================
    // next state
    logic          do_write;
    logic          do_read;
    logic          advance;
    logic [31:0]   wval;
    logic [31:0]   mode_rd;
    logic [NM:0]   flag_set;
    logic [NM:0]   flag_clr;
    logic [NM:0]   flag_en;

    always_comb begin
        cnt_d       = cnt_q;
        snap_d      = snap_q;
        idle_halt_d = idle_halt_q;
        tb_sel_d    = tb_sel_q;
        ovf_en_d    = ovf_en_q;
        wdog_d      = wdog_q;
        mod_en_d    = mod_en_q;
        array_en_d  = array_en_q;
        io_d        = io_q;
        io_oe_d     = io_oe_q;
        aw_have_d   = aw_have_q;
        aw_addr_d   = aw_addr_q;
        w_have_d    = w_have_q;
        w_data_d    = w_data_q;
        w_strb_d    = w_strb_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        rvalid_d    = rvalid_q;
        rdata_d     = rdata_q;
        rresp_d     = rresp_q;
        flag_clr    = '0;

        mode_rd = '0;
        mode_rd[cati_pkg::MODE_IDLE_BIT]                   = idle_halt_q;
        mode_rd[cati_pkg::MODE_TB_LSB +: 3]                = tb_sel_q;
        mode_rd[cati_pkg::MODE_OVF_EN]                     = ovf_en_q;
        mode_rd[cati_pkg::MODE_WDOG]                       = wdog_q;

        // write channels are taken independently, in either order
        if (s_axi_awvalid && !aw_have_q && !bvalid_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q && !bvalid_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        do_write = aw_have_q && w_have_q && !bvalid_q;
        wval     = 32'h0;
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped(aw_addr_q) ? cati_pkg::RESP_OKAY : cati_pkg::RESP_SLVERR;
            case (aw_addr_q)
                cati_pkg::ADDR_MODE: begin
                    wval = merge(mode_rd, w_data_q, w_strb_q);
                    // watchdog mode locks the timebase setup; only its own bit may be cleared
                    if (!wdog_q) begin
                        idle_halt_d = wval[cati_pkg::MODE_IDLE_BIT];
                        tb_sel_d    = wval[cati_pkg::MODE_TB_LSB +: 3];
                        ovf_en_d    = wval[cati_pkg::MODE_OVF_EN];
                    end
                    wdog_d = wval[cati_pkg::MODE_WDOG];
                end
                cati_pkg::ADDR_FLAGS: begin
                    // write one to clear; hardware never clears a flag on its own
                    flag_clr = w_data_q[NM:0] & {(NM+1){w_strb_q[0]}};
                end
                cati_pkg::ADDR_IRQEN: begin
                    wval       = merge({26'h0, array_en_q, mod_en_q}, w_data_q, w_strb_q);
                    mod_en_d   = wval[NM-1:0];
                    array_en_d = wval[cati_pkg::IRQ_ARRAY_BIT];
                end
                cati_pkg::ADDR_CNT_LO: begin
                    if (!wdog_q && w_strb_q[0]) begin
                        cnt_d[7:0] = w_data_q[7:0];
                    end
                end
                cati_pkg::ADDR_CNT_HI: begin
                    if (!wdog_q && w_strb_q[0]) begin
                        cnt_d[15:8] = w_data_q[7:0];
                    end
                end
                cati_pkg::ADDR_IO: begin
                    wval    = merge({19'h0, io_oe_q, 3'h0, io_q}, w_data_q, w_strb_q);
                    io_d    = wval[NM-1:0];
                    io_oe_d = wval[cati_pkg::IO_OE_LSB +: NM];
                end
                default: ;
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end

        // read: one in flight; low byte read takes the high byte snapshot
        do_read = s_axi_arvalid && !rvalid_q;
        if (do_read) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(s_axi_araddr) ? cati_pkg::RESP_OKAY : cati_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                cati_pkg::ADDR_MODE:   rdata_d = mode_rd;
                cati_pkg::ADDR_FLAGS:  rdata_d = {26'h0, flags_q};
                cati_pkg::ADDR_IRQEN:  rdata_d = {26'h0, array_en_q, mod_en_q};
                cati_pkg::ADDR_CNT_LO: begin
                    rdata_d = {24'h0, cnt_q[7:0]};
                    snap_d  = cnt_q[15:8];
                end
                cati_pkg::ADDR_CNT_HI: rdata_d = {24'h0, snap_q};
                cati_pkg::ADDR_IO:     rdata_d = {19'h0, io_oe_q, 3'h0, io_q};
                default:               rdata_d = 32'h0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end

        // counting ignores every bus read; idle halts only when asked to
        advance = tick && !(idle_halt_q && cpu_idle);
        if (advance) begin
            cnt_d = cnt_q + 16'h1;
        end

        // flags: a trigger in the same cycle as a clear wins
        flag_set                                = '0;
        flag_set[cati_pkg::FLAG_OVF]            = advance && (cnt_q == 16'hffff);
        flag_set[cati_pkg::FLAG_MOD_LSB +: NM]  = module_event;
        flags_d = (flags_q & ~flag_clr) | flag_set;

        flag_en = {mod_en_q, ovf_en_q};
        irq_d   = (|(flags_q & flag_en)) && array_en_q && global_irq_enable;
    end

    // =================================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q       <= 16'h0;
            snap_q      <= 8'h0;
            idle_halt_q <= 1'b0;
            tb_sel_q    <= cati_pkg::TB_DIV12;
            ovf_en_q    <= 1'b0;
            wdog_q      <= 1'b1;
            flags_q     <= '0;
            mod_en_q    <= '0;
            array_en_q  <= 1'b0;
            io_q        <= '0;
            io_oe_q     <= '0;
            irq_q       <= 1'b0;
            aw_have_q   <= 1'b0;
            aw_addr_q   <= 8'h0;
            w_have_q    <= 1'b0;
            w_data_q    <= 32'h0;
            w_strb_q    <= 4'h0;
            bvalid_q    <= 1'b0;
            bresp_q     <= cati_pkg::RESP_OKAY;
            rvalid_q    <= 1'b0;
            rdata_q     <= 32'h0;
            rresp_q     <= cati_pkg::RESP_OKAY;
        end else begin
            cnt_q       <= cnt_d;
            snap_q      <= snap_d;
            idle_halt_q <= idle_halt_d;
            tb_sel_q    <= tb_sel_d;
            ovf_en_q    <= ovf_en_d;
            wdog_q      <= wdog_d;
            flags_q     <= flags_d;
            mod_en_q    <= mod_en_d;
            array_en_q  <= array_en_d;
            io_q        <= io_d;
            io_oe_q     <= io_oe_d;
            irq_q       <= irq_d;
            aw_have_q   <= aw_have_d;
            aw_addr_q   <= aw_addr_d;
            w_have_q    <= w_have_d;
            w_data_q    <= w_data_d;
            w_strb_q    <= w_strb_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            rvalid_q    <= rvalid_d;
            rdata_q     <= rdata_d;
            rresp_q     <= rresp_d;
        end
    end

    // =================================================================
    // outputs
    assign s_axi_awready  = !aw_have_q && !bvalid_q;
    assign s_axi_wready   = !w_have_q && !bvalid_q;
    assign s_axi_bvalid   = bvalid_q;
    assign s_axi_bresp    = bresp_q;
    assign s_axi_arready  = !rvalid_q;
    assign s_axi_rvalid   = rvalid_q;
    assign s_axi_rdata    = rdata_q;
    assign s_axi_rresp    = rresp_q;
    assign array_irq      = irq_q;
    assign module_io_line = io_q;
    assign module_io_oe   = io_oe_q;
endmodule // cati_top

// file: test/cati_props.sv
// port-level assertions for the counter array block
`timescale 1ns/10ps
module cati_props (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // core side
    input wire logic        global_irq_enable,
    input wire logic        array_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // interrupt
    a_irq_global_gate: assert property (!global_irq_enable |=> !array_irq)
        else $error("irq seen with global enable low");
    // readies high: no write lands, flags hold
    a_irq_pending_hold: assert property (array_irq && global_irq_enable && s_axi_awready
        && s_axi_wready |=> array_irq)
        else $error("irq dropped without a clearing write");
    // ==========================================================
    // bus
    a_ar_ready_rule: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    a_r_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed before taken");
    a_b_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer changed before taken");
    a_r_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_w_refuse_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while response pending");
    a_b_after_take: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready)
        && !$past(s_axi_wready))
        else $error("write answer without taken request");
    a_r_resp_code: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
        else $error("illegal read response");
    c_irq_rise: cover property ($rose(array_irq));
    c_read_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // cati_props
bind cati_top cati_props u_props (.*);

// file: test/cati_pin_model.sv
// pin-side source model: external count pulses and a free oscillator
`timescale 1ns/10ps
module cati_pin_model (
    // clock
    input wire logic aclk,
    // control
    input wire logic ext_go,
    // pins
    output logic     ext_count_input,
    output logic     ext_osc_in
);
    int n_left = 0;
    int ph     = 0;
    initial begin
        ext_count_input = 1'b1;
        ext_osc_in      = 1'b0;
    end
    // free-running, unrelated to aclk
    always #230 ext_osc_in = ~ext_osc_in;
    // 8 falling edges per request, each level 4 clocks
    always @(posedge aclk) begin
        if (ext_go) begin
            n_left <= 8;
        end else if (n_left > 0) begin
            ph <= ph + 1;
            if (ph == 3) ext_count_input <= 1'b0;
            if (ph == 7) begin
                ext_count_input <= 1'b1;
                ph              <= 0;
                n_left          <= n_left - 1;
            end
        end
    end
endmodule // cati_pin_model

// file: test/tb_top.sv
// self-checking bench for the counter array block
`timescale 1ns/10ps
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic global_irq_enable = 1'b0, cpu_idle = 1'b1, timer0_ovf = 1'b0, ext_go = 1'b0;
    logic [4:0] module_event = 5'h0;
    logic array_irq, ext_count_input, ext_osc_in;
    logic [4:0] module_io_line, module_io_oe;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cati_exp_s;
    cati_exp_s q[$], e;
    int n_errors = 0, n_tests = 0;
    logic [31:0] rd, seed = 32'd23579;
    cati_top DUT (.*);
    cati_pin_model u_pins (.*);
    always #10 aclk = ~aclk;
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_tests++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic irq_is(input logic v);
        chk({31'h0, array_irq}, {31'h0, v}, 32'h1);
    endtask
    task automatic finish_test;
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, r}, 32'h3);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [1:0] r = 2'h0);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        q.push_back('{d, m, r});
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    always @(posedge aclk) begin
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            e = q.pop_front();
            chk(s_axi_rdata, e.d, e.m);
            chk({30'h0, s_axi_rresp}, {30'h0, e.r}, 32'h3);
        end
    end
    // count n clocks, then halt and read both bytes
    task automatic win(input logic [2:0] sel, input int n, input int lo, input int hi);
        logic [15:0] c;
        wr(cati_pkg::ADDR_MODE, {28'h0, sel, 1'b1});
        wr(cati_pkg::ADDR_CNT_LO, 32'h0);
        wr(cati_pkg::ADDR_CNT_HI, 32'h0);
        cpu_idle <= 1'b0;
        ext_go   <= (sel == cati_pkg::TB_EXT_IN);
        for (int k = 0; k < n; k++) begin
            @(posedge aclk);
            ext_go     <= 1'b0;
            timer0_ovf <= (sel == cati_pkg::TB_T0_OVF) && (k % 10 == 0) && (k < n - 20);
        end
        cpu_idle <= 1'b1;
        tick(8);
        rdr(cati_pkg::ADDR_CNT_LO, 32'h0, 32'h0);
        c[7:0] = rd[7:0];
        rdr(cati_pkg::ADDR_CNT_HI, 32'h0, 32'h0);
        c[15:8] = rd[7:0];
        n_tests++;
        if ((c >= lo && c <= hi) !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, c, lo);
        end
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        finish_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        tick(20);
        aresetn <= 1'b1;
        rdr(cati_pkg::ADDR_MODE, 32'h20, 32'hff);
        rdr(cati_pkg::ADDR_FLAGS, 32'h0, 32'h3f);
        wr(cati_pkg::ADDR_MODE, 32'h28);
        rdr(cati_pkg::ADDR_MODE, 32'h20, 32'hff);
        wr(cati_pkg::ADDR_MODE, 32'h0);
        rdr(8'h18, 32'h0, 32'h0, cati_pkg::RESP_SLVERR);
        wr(8'h18, 32'h0, cati_pkg::RESP_SLVERR);
        win(cati_pkg::TB_DIV12, 1200, 99, 101);
        win(cati_pkg::TB_DIV4, 400, 99, 101);
        win(cati_pkg::TB_SYSCLK, 100, 98, 102);
        win(cati_pkg::TB_T0_OVF, 200, 18, 18);
        win(cati_pkg::TB_EXT_IN, 100, 8, 8);
        win(cati_pkg::TB_OSC8, 1840, 9, 11);
        wr(cati_pkg::ADDR_MODE, 32'h19);
        wr(cati_pkg::ADDR_CNT_LO, 32'hfc);
        wr(cati_pkg::ADDR_CNT_HI, 32'hff);
        wr(cati_pkg::ADDR_IRQEN, 32'h20);
        global_irq_enable <= 1'b1;
        tick(3);
        irq_is(1'b0);
        cpu_idle <= 1'b0;
        tick(10);
        cpu_idle <= 1'b1;
        tick(3);
        irq_is(1'b1);
        global_irq_enable <= 1'b0;
        tick(3);
        irq_is(1'b0);
        global_irq_enable <= 1'b1;
        rdr(cati_pkg::ADDR_FLAGS, 32'h1, 32'h3f);
        wr(cati_pkg::ADDR_FLAGS, 32'h1);
        tick(2);
        irq_is(1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(cati_pkg::ADDR_IRQEN, 32'h20);
            module_event <= 5'h1 << i;
            tick(1);
            module_event <= 5'h0;
            tick(3);
            irq_is(1'b0);
            rdr(cati_pkg::ADDR_FLAGS, 32'h2 << i, 32'h3f);
            wr(cati_pkg::ADDR_IRQEN, 32'h20 | (32'h1 << i));
            tick(2);
            irq_is(1'b1);
            wr(cati_pkg::ADDR_FLAGS, 32'h2 << i);
            tick(2);
            irq_is(1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            wr(cati_pkg::ADDR_IO, seed & 32'h1f1f);
            tick(2);
            chk({19'h0, module_io_oe, 3'h0, module_io_line}, seed, 32'h1f1f);
        end
        wr(cati_pkg::ADDR_CNT_LO, 32'hf0);
        wr(cati_pkg::ADDR_CNT_HI, 32'h0);
        wr(cati_pkg::ADDR_MODE, {28'h0, cati_pkg::TB_SYSCLK, 1'b0});
        rdr(cati_pkg::ADDR_CNT_LO, 32'hf0, 32'hf0);
        tick(40);
        rdr(cati_pkg::ADDR_CNT_HI, 32'h0, 32'hff);
        rdr(cati_pkg::ADDR_CNT_LO, 32'h0, 32'h0);
        rdr(cati_pkg::ADDR_CNT_HI, 32'h1, 32'hff);
        tick(2);
        finish_test();
    end
endmodule // tb_top
